// ===== rtl/xip_pkg.sv
package xip_pkg;

  localparam logic [7:0] PRIO_ADDR   = 8'hF6;
  localparam logic [7:0] ENABLE_ADDR = 8'hE6;
  localparam logic [7:0] PRIO_RESET  = 8'h00;
  localparam logic [7:0] RDATA_IDLE  = 8'h00;

  localparam int BIT_TIMER3  = 7;
  localparam int BIT_CMP1    = 6;
  localparam int BIT_CMP0    = 5;
  localparam int BIT_CNTARR  = 4;
  localparam int BIT_CONVDN  = 3;
  localparam int BIT_WINCMP  = 2;
  localparam int BIT_USBFN   = 1;
  localparam int BIT_SMBUS   = 0;
  localparam int NUM_SRC     = 8;

endpackage : xip_pkg

// ===== rtl/xip_priority.sv
`timescale 1ns/1ps
module xip_priority (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_sel_o,
  input  wire logic [7:0] extended_enable_one_i,
  input  wire logic [7:0] src_pending_i,
  input  wire logic       in_high_isr_i,
  input  wire logic       in_low_isr_i,
  output logic      [7:0] extended_priority_select_one_o,
  output logic            req_high_o,
  output logic            req_low_o,
  output logic      [7:0] grant_onehot_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage and the byte-wide read path
  logic [7:0] extended_priority_select_one_ff;
  logic [7:0] nxt_extended_priority_select_one;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       hit;
  logic       wr_hit;
  logic       rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // one named wire per priority field
  logic       timer_three_priority;
  logic       comparator_one_priority;
  logic       comparator_zero_priority;
  logic       counter_array_priority;
  logic       conversion_done_priority;
  logic       window_compare_priority;
  logic       usb_function_priority;
  logic       smbus_engine_priority;

  // one named wire per field of the companion enable register
  logic       en_timer_three;
  logic       en_comparator_one;
  logic       en_comparator_zero;
  logic       en_counter_array;
  logic       en_conversion_done;
  logic       en_window_compare;
  logic       en_usb_function;
  logic       en_smbus_engine;

  // one named wire per source flag
  logic       pend_timer_three;
  logic       pend_comparator_one;
  logic       pend_comparator_zero;
  logic       pend_counter_array;
  logic       pend_conversion_done;
  logic       pend_window_compare;
  logic       pend_usb_function;
  logic       pend_smbus_engine;

  // request and arbitration nets
  logic [7:0] prio_vec;
  logic [7:0] enable_vec;
  logic [7:0] pend_vec;
  logic [7:0] live_req;
  logic [7:0] high_req;
  logic [7:0] low_req;
  logic [7:0] high_pick;
  logic [7:0] low_pick;
  logic [7:0] grant;
  logic       any_high;
  logic       any_low;
  logic       high_blocked;
  logic       low_blocked;
  logic       take_high;
  logic       take_low;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign hit       = (sfr_addr_i == xip_pkg::PRIO_ADDR);
  assign wr_hit    = sfr_wr_i && hit;
  assign rd_hit    = sfr_rd_i && hit;
  assign sfr_sel_o = hit;

  // a read in the write cycle returns the old value, not the new one
  assign nxt_rdata = rd_hit ? extended_priority_select_one_ff : xip_pkg::RDATA_IDLE;
  assign nxt_extended_priority_select_one = wr_hit ?
                                            sfr_wdata_i :
                                            extended_priority_select_one_ff;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      extended_priority_select_one_ff <= xip_pkg::PRIO_RESET;
    end else begin
      extended_priority_select_one_ff <= nxt_extended_priority_select_one;
    end
  end

  // read data stands one cycle only; idle value otherwise
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= xip_pkg::RDATA_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata_o                    = rdata_ff;
  assign extended_priority_select_one_o = extended_priority_select_one_ff;

  ////////////////////////////////////////////////////////////////////////////
  // field split, bit positions from the package
  assign timer_three_priority     = extended_priority_select_one_ff[xip_pkg::BIT_TIMER3];
  assign comparator_one_priority  = extended_priority_select_one_ff[xip_pkg::BIT_CMP1];
  assign comparator_zero_priority = extended_priority_select_one_ff[xip_pkg::BIT_CMP0];
  assign counter_array_priority   = extended_priority_select_one_ff[xip_pkg::BIT_CNTARR];
  assign conversion_done_priority = extended_priority_select_one_ff[xip_pkg::BIT_CONVDN];
  assign window_compare_priority  = extended_priority_select_one_ff[xip_pkg::BIT_WINCMP];
  assign usb_function_priority    = extended_priority_select_one_ff[xip_pkg::BIT_USBFN];
  assign smbus_engine_priority    = extended_priority_select_one_ff[xip_pkg::BIT_SMBUS];

  // enable split
  assign en_timer_three     = extended_enable_one_i[xip_pkg::BIT_TIMER3];
  assign en_comparator_one  = extended_enable_one_i[xip_pkg::BIT_CMP1];
  assign en_comparator_zero = extended_enable_one_i[xip_pkg::BIT_CMP0];
  assign en_counter_array   = extended_enable_one_i[xip_pkg::BIT_CNTARR];
  assign en_conversion_done = extended_enable_one_i[xip_pkg::BIT_CONVDN];
  assign en_window_compare  = extended_enable_one_i[xip_pkg::BIT_WINCMP];
  assign en_usb_function    = extended_enable_one_i[xip_pkg::BIT_USBFN];
  assign en_smbus_engine    = extended_enable_one_i[xip_pkg::BIT_SMBUS];

  // flag split
  assign pend_timer_three     = src_pending_i[xip_pkg::BIT_TIMER3];
  assign pend_comparator_one  = src_pending_i[xip_pkg::BIT_CMP1];
  assign pend_comparator_zero = src_pending_i[xip_pkg::BIT_CMP0];
  assign pend_counter_array   = src_pending_i[xip_pkg::BIT_CNTARR];
  assign pend_conversion_done = src_pending_i[xip_pkg::BIT_CONVDN];
  assign pend_window_compare  = src_pending_i[xip_pkg::BIT_WINCMP];
  assign pend_usb_function    = src_pending_i[xip_pkg::BIT_USBFN];
  assign pend_smbus_engine    = src_pending_i[xip_pkg::BIT_SMBUS];

  ////////////////////////////////////////////////////////////////////////////
  // regather in source order so the arbiter sees one vector per input
  assign prio_vec[xip_pkg::BIT_TIMER3] = timer_three_priority;
  assign prio_vec[xip_pkg::BIT_CMP1]   = comparator_one_priority;
  assign prio_vec[xip_pkg::BIT_CMP0]   = comparator_zero_priority;
  assign prio_vec[xip_pkg::BIT_CNTARR] = counter_array_priority;
  assign prio_vec[xip_pkg::BIT_CONVDN] = conversion_done_priority;
  assign prio_vec[xip_pkg::BIT_WINCMP] = window_compare_priority;
  assign prio_vec[xip_pkg::BIT_USBFN]  = usb_function_priority;
  assign prio_vec[xip_pkg::BIT_SMBUS]  = smbus_engine_priority;

  assign enable_vec[xip_pkg::BIT_TIMER3] = en_timer_three;
  assign enable_vec[xip_pkg::BIT_CMP1]   = en_comparator_one;
  assign enable_vec[xip_pkg::BIT_CMP0]   = en_comparator_zero;
  assign enable_vec[xip_pkg::BIT_CNTARR] = en_counter_array;
  assign enable_vec[xip_pkg::BIT_CONVDN] = en_conversion_done;
  assign enable_vec[xip_pkg::BIT_WINCMP] = en_window_compare;
  assign enable_vec[xip_pkg::BIT_USBFN]  = en_usb_function;
  assign enable_vec[xip_pkg::BIT_SMBUS]  = en_smbus_engine;

  assign pend_vec[xip_pkg::BIT_TIMER3] = pend_timer_three;
  assign pend_vec[xip_pkg::BIT_CMP1]   = pend_comparator_one;
  assign pend_vec[xip_pkg::BIT_CMP0]   = pend_comparator_zero;
  assign pend_vec[xip_pkg::BIT_CNTARR] = pend_counter_array;
  assign pend_vec[xip_pkg::BIT_CONVDN] = pend_conversion_done;
  assign pend_vec[xip_pkg::BIT_WINCMP] = pend_window_compare;
  assign pend_vec[xip_pkg::BIT_USBFN]  = pend_usb_function;
  assign pend_vec[xip_pkg::BIT_SMBUS]  = pend_smbus_engine;

  ////////////////////////////////////////////////////////////////////////////
  // masked sources never reach either level, whatever their priority bit
  assign live_req = pend_vec & enable_vec;
  assign high_req = live_req & prio_vec;
  assign low_req  = live_req & ~prio_vec;
  assign any_high = |high_req;
  assign any_low  = |low_req;

  // high may interrupt idle or low code; low only idle code
  assign high_blocked = in_high_isr_i;
  assign low_blocked  = in_high_isr_i || in_low_isr_i;
  assign take_high    = any_high && !high_blocked;
  assign take_low     = !take_high && any_low && !low_blocked;
  assign req_high_o   = take_high;
  assign req_low_o    = take_low;

  ////////////////////////////////////////////////////////////////////////////
  // within a level the highest bit index wins; fixed order, no rotation,
  // so a busy high-index source can starve lower ones of its own level
  genvar g;
  generate
    for (g = 0; g < xip_pkg::NUM_SRC; g++) begin : g_pick
      if (g == xip_pkg::NUM_SRC - 1) begin : g_top
        assign high_pick[g] = high_req[g];
        assign low_pick[g]  = low_req[g];
      end else begin : g_rest
        assign high_pick[g] = high_req[g] & ~(|high_req[xip_pkg::NUM_SRC-1:g+1]);
        assign low_pick[g]  = low_req[g] & ~(|low_req[xip_pkg::NUM_SRC-1:g+1]);
      end
    end
  endgenerate

  // the level choice picks which one-hot reaches the core
  assign grant          = take_high ? high_pick : (take_low ? low_pick : 8'h00);
  assign grant_onehot_o = grant;

endmodule // xip_priority

// ===== bench/xip_checker.sv
`timescale 1ns/1ps
module xip_checker(input logic clk_sys_i,resetn_i,sfr_wr_i,sfr_rd_i,sfr_sel_o,in_high_isr_i,
input logic in_low_isr_i,req_high_o,req_low_o,
input logic [7:0] sfr_wdata_i,sfr_rdata_o,src_pending_i,extended_enable_one_i,grant_onehot_o,
extended_priority_select_one_o);
wire [7:0] r=extended_priority_select_one_o,l=extended_enable_one_i&src_pending_i,h=r&l;
default clocking @(posedge clk_sys_i);endclocking
default disable iff(!resetn_i);
property p_wr;sfr_wr_i&&sfr_sel_o|=>r==$past(sfr_wdata_i);endproperty
a_wr:assert property(p_wr)else $error("register missed write");
property p_keep;!(sfr_wr_i&&sfr_sel_o)|=>r==$past(r);endproperty
a_keep:assert property(p_keep)else $error("register changed without write");
property p_rd;sfr_rd_i&&sfr_sel_o|=>sfr_rdata_o==$past(r);endproperty
a_rd:assert property(p_rd)else $error("read data wrong");
property p_hi;(h!=8'h00)&&!in_high_isr_i|->req_high_o;endproperty
a_hi:assert property(p_hi)else $error("high request missing");
property p_mask;(l==8'h00)|->!req_high_o&&!req_low_o&&grant_onehot_o==8'h00;endproperty
a_mask:assert property(p_mask)else $error("masked source requested");
property p_lo;req_low_o|->!in_low_isr_i&&!in_high_isr_i&&!req_high_o;endproperty
a_lo:assert property(p_lo)else $error("low request while blocked");
property p_lvl;req_high_o|->$onehot(grant_onehot_o)&&(grant_onehot_o&~h)==8'h00;endproperty
a_lvl:assert property(p_lvl)else $error("high grant not a high source");
endmodule // xip_checker
bind xip_priority xip_checker u_xip_checker(.*);

// ===== bench/xip_core_model.sv
`timescale 1ns/1ps
module xip_core_model(input logic clk_sys_i,md_i,output logic in_low_isr_i=0);
always @(posedge clk_sys_i) in_low_isr_i<=md_i;
endmodule // xip_core_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
logic clk_sys_i=0,resetn_i=0,sfr_wr_i=0,sfr_rd_i=0,md_i=0,sfr_sel_o,req_high_o,req_low_o;
logic in_high_isr_i=0,in_low_isr_i;logic [7:0] sfr_addr_i=8'hF6,sfr_wdata_i=8'h00,sfr_rdata_o;
logic [7:0] src_pending_i=8'hFF,extended_enable_one_i=8'h00,extended_priority_select_one_o;
logic [7:0] grant_onehot_o;int fail_count=0,comparisons=0;
initial forever #12.5 clk_sys_i=~clk_sys_i;
xip_priority u_xip_priority(.*);
xip_core_model u_xip_core_model(.*);
task chk(string n,logic [9:0] e,s);comparisons++;if(e!==s)begin fail_count++;
$display("[FAIL] %s %h %h",n,e,s);end endtask
task acc(logic w,logic [7:0] d);@(posedge clk_sys_i);#1 sfr_wr_i=w;sfr_rd_i=!w;sfr_wdata_i=d;
@(posedge clk_sys_i);#1 sfr_wr_i=0;sfr_rd_i=0;endtask
task t_bits;for(int i=0;i<8;i++)begin acc(1,8'h01<<i);acc(0,8'h00);
chk("rd",8'h01<<i,sfr_rdata_o);extended_enable_one_i=8'h01<<i;end endtask
task stp;@(posedge clk_sys_i);#1;endtask
task t_low;md_i=0;acc(1,8'h00);extended_enable_one_i=8'hFF;#1
chk("low",10'h180,{req_high_o,req_low_o,grant_onehot_o});
stp;in_high_isr_i=1;#1 chk("hold",10'h000,{req_high_o,req_low_o,grant_onehot_o});
stp;in_high_isr_i=0;extended_enable_one_i=8'h00;#1
chk("mask",10'h000,{req_high_o,req_low_o,grant_onehot_o});
stp;sfr_addr_i=8'hE6;acc(1,8'hFF);acc(0,8'h00);chk("sel",1'b0,sfr_sel_o);
chk("oth",8'h00,sfr_rdata_o);chk("keep",8'h00,extended_priority_select_one_o);
stp;sfr_addr_i=8'hF6;endtask
task t_pre;md_i=1;extended_enable_one_i=8'hFF;repeat(2)@(posedge clk_sys_i);#1
chk("pre",9'h180,{req_high_o,grant_onehot_o});endtask
task report_and_stop;if(fail_count==0&&comparisons>0)$display("[ PASS ]");
else $display("[ FAIL ]");$finish;endtask
initial begin repeat(6)@(posedge clk_sys_i);#1 resetn_i=1;
chk("rst",8'h00,extended_priority_select_one_o);t_bits;t_pre;t_low;report_and_stop;end
endmodule // tb_top
